// file: common/tdl_pkg.sv
/*
 * Shared constants for the T1 data link and signaling control block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a byte-wide register port with printed offsets as addresses.
 */
`default_nettype none

package tdl_pkg;

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 8;
   localparam logic [7:0]  OFS_DL_CTRL     = 8'h12;
   localparam logic [7:0]  OFS_TX_BOM      = 8'h13;
   localparam logic [7:0]  OFS_SIG_CTRL    = 8'h14;
   localparam logic [7:0]  OFS_RXSIG_BASE  = 8'h40;
   localparam logic [7:0]  RST_DL_CTRL     = 8'h00;
   localparam logic [7:0]  RST_TX_BOM      = 8'h00;
   localparam logic [7:0]  RST_SIG_CTRL    = 8'h00;

   // ------------------------------------------------------------
   // Data link control fields
   // ------------------------------------------------------------
   localparam int BIT_EXTERNAL_LINK_ENABLE   = 7;
   localparam int BIT_BIT_MESSAGE_ENABLE     = 6;
   localparam int BIT_FDL_HDLC_SELECT        = 5;
   localparam int BIT_CHANNEL24_HDLC_SELECT  = 4;
   localparam int BIT_TX_MULTIFRAME_ALIGN    = 3;
   localparam int BIT_TRANSPARENT_SELECT     = 2;
   localparam int BIT_JAPAN_CRC_SBIT_INCLUDE = 1;
   localparam int BIT_CHANNEL24_RATE_SELECT  = 0;

   // ------------------------------------------------------------
   // Signaling control fields
   // ------------------------------------------------------------
   localparam int BIT_SERIAL_OUT_DRIVE_ENABLE    = 7;
   localparam int BIT_SIGNALING_OUT_DRIVE_ENABLE = 6;
   localparam int BIT_ROBBED_BIT_ENABLE          = 5;
   localparam int BIT_SIGNALING_DEBOUNCE_ENABLE  = 4;
   localparam int BIT_UPPER_NIBBLE_SELECT        = 3;
   localparam int BIT_SIGNALING_MESSAGE_HI       = 2;
   localparam int BIT_SIGNALING_MESSAGE_LO       = 1;

   // ------------------------------------------------------------
   // Framing and timing
   // ------------------------------------------------------------
   localparam int          NUM_CH          = 24;
   localparam logic [2:0]  RB_FRAME_LAST   = 3'h5;
   localparam logic [2:0]  CH_BIT8_IDX     = 3'h7;
   localparam logic [7:0]  BOM_FLAG        = 8'hFF;
   localparam logic [3:0]  BOM_LEN_LAST    = 4'hF;
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          T_MS_NS         = 1000000;
   localparam int          MS_CYCLES       = T_MS_NS / CLK_PERIOD_NS;
   localparam int          DB_MIN_MS       = 6;
   localparam int          DB_MAX_MS       = 9;
   // Ticks counted after the last change: elapsed time lands in 6..7 ms
   localparam logic [2:0]  DB_TICKS        = 3'h7;

endpackage : tdl_pkg

`default_nettype wire

// file: rtl/tdl_ctrl.sv
/*
 * T1 transmit data link source selection, channel 24 HDLC rate, transparent
 * and alignment controls, and the signaling path: robbed-bit framing, receive
 * debounce, nibble select and backplane output enables.
 * Assumes the line framer presents slot requests as one-cycle strobes
 * synchronous to clk_sys, and that the HDLC engines live outside.
 */
// Operation
// - External link enable routes the data link input pin into FDL or Fs bits.
// - Message enable sends the transmit message register on the ESF data link.
// - Received bit-oriented message capture stays on regardless of transmit enable.
// - FDL HDLC select makes the internal HDLC the ESF FDL bit source.
// - Channel 24 HDLC select makes the internal HDLC the channel 24 source.
// - HDLC receivers always stay enabled; only their interrupts are maskable.
// - Multiframe align locks transmit multiframe to S bits on channel 31 bit 0.
// - Transparent mode sends input channels 0-23 and 31 bit 0 unframed.
// - Transparent mode returns unframed line data on output channels 0-23.
// - Japanese option includes S bits in the CRC-6 computation.
// - Channel 24 rate bit high gives 64 kb/s, low gives 56 kb/s.
// - Message byte joined with eight ones repeats in the ESF FDL position.
// - Serial data output floats while its drive enable is zero.
// - Signaling output floats while its drive enable is zero.
// - Robbed-bit enable inserts signaling into bit 8 every sixth frame.
// - Debounce holds received signaling changes back 6 to 9 ms.
// - Upper nibble select uses upper nibbles and floats the lower output nibble.
// - Lower nibble in use otherwise, upper output nibble floats.
// - D4 nibbles report A, B then message bits; ESF nibbles report ABCD.
`timescale 1ns/100ps
`default_nettype none

module tdl_ctrl #(
   parameter int MS_CYCLES = tdl_pkg::MS_CYCLES
) (
   // Clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          nrst,
   // Register port
   input  wire logic [tdl_pkg::ADDR_W-1:0]    reg_addr,
   input  wire logic [tdl_pkg::DATA_W-1:0]    reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [tdl_pkg::DATA_W-1:0]    reg_rdata,
   // Framer mode
   input  wire logic                          esf_mode,
   // Overhead data link slot
   input  wire logic                          ovh_req,
   input  wire logic                          tx_dl_in,
   input  wire logic                          hdlc_fdl_bit,
   output logic                               hdlc_fdl_take,
   output logic                               ovh_valid,
   output logic                               ovh_bit,
   // Channel 24 slot
   input  wire logic                          ch24_req,
   input  wire logic [2:0]                    ch24_bit_idx,
   input  wire logic                          hdlc_ch24_bit,
   output logic                               hdlc_ch24_take,
   output logic                               ch24_valid,
   output logic                               ch24_bit,
   output logic                               ch24_use_hdlc,
   // Multiframe alignment from backplane
   input  wire logic                          ch31b0_valid,
   input  wire logic                          ch31b0_bit,
   output logic                               tx_mf_align,
   output logic                               tx_mf_sbit,
   // Line framer controls
   output logic                               tx_unframed,
   output logic                               rx_unframed,
   output logic                               crc_sbit_include,
   output logic                               rx_bom_capture_en,
   output logic                               hdlc_rx_enable,
   // Robbed-bit signaling
   input  wire logic                          frame_start,
   input  wire logic                          tx_sig_valid,
   input  wire logic [7:0]                    backplane_signaling_input,
   output logic                               rb_insert_frame,
   output logic      [3:0]                    tx_sig_nibble,
   // Receive signaling
   input  wire logic                          rx_sig_valid,
   input  wire logic [4:0]                    rx_sig_ch,
   input  wire logic [3:0]                    rx_sig_abcd,
   output logic      [7:0]                    backplane_signaling_output,
   output logic      [7:0]                    backplane_signaling_output_oe,
   // Serial data output
   input  wire logic                          line_data,
   output logic                               backplane_data_output,
   output logic                               backplane_data_output_oe
);
   import tdl_pkg::*;

   localparam int MS_W = $clog2(MS_CYCLES + 1);

   generate
      if (MS_CYCLES < 2) begin : g_bad_ms
         $error("MS_CYCLES must be at least 2");
      end
   endgenerate

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]               dl_ctrl;
      logic [7:0]               tx_bom;
      logic [7:0]               sig_ctrl;
      logic [7:0]               rdata;
      logic [3:0]               bom_idx;
      logic                     ovh_valid;
      logic                     ovh_bit;
      logic                     fdl_take;
      logic                     ch24_valid;
      logic                     ch24_bit;
      logic                     ch24_take;
      logic                     mf_align;
      logic                     mf_sbit;
      logic [2:0]               frame_cnt;
      logic                     rb_frame;
      logic [3:0]               tx_nib;
      logic [MS_W-1:0]          ms_cnt;
      logic [NUM_CH-1:0][3:0]   stable;
      logic [NUM_CH-1:0][3:0]   cand;
      logic [NUM_CH-1:0][2:0]   db_cnt;
      logic [7:0]               cst_out;
      logic                     dout;
   } tdl_state_s;

   tdl_state_s st_ff;
   tdl_state_s nxt_st;

   logic        ext_en;
   logic        bom_en;
   logic        fdl_hdlc_en;
   logic        c24_hdlc_en;
   logic        rate64;
   logic        db_en;
   logic        hi_sel;
   logic        ms_tick;
   logic [15:0] bom_pat;

   assign ext_en   = st_ff.dl_ctrl[BIT_EXTERNAL_LINK_ENABLE];
   assign bom_en   = st_ff.dl_ctrl[BIT_BIT_MESSAGE_ENABLE];
   assign fdl_hdlc_en = st_ff.dl_ctrl[BIT_FDL_HDLC_SELECT];
   assign c24_hdlc_en = st_ff.dl_ctrl[BIT_CHANNEL24_HDLC_SELECT];
   assign rate64   = st_ff.dl_ctrl[BIT_CHANNEL24_RATE_SELECT];
   assign db_en    = st_ff.sig_ctrl[BIT_SIGNALING_DEBOUNCE_ENABLE];
   assign hi_sel   = st_ff.sig_ctrl[BIT_UPPER_NIBBLE_SELECT];
   assign ms_tick  = (st_ff.ms_cnt == MS_W'(MS_CYCLES - 1));
   assign bom_pat  = {BOM_FLAG, st_ff.tx_bom};

   // ------------------------------------------------------------
   // Reported nibble format
   // ------------------------------------------------------------
   function automatic logic [3:0] fmt_nib(input logic [3:0] abcd,
                                          input logic       esf,
                                          input logic [1:0] smsg);
      fmt_nib = esf ? abcd : {abcd[3:2], smsg};
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      int         i;
      logic [4:0] ch;
      logic [3:0] rep;
      nxt_st = st_ff;
      i      = 0;
      ch     = rx_sig_ch;
      rep    = 4'h0;

      // Register writes and reads
      if (reg_wr) begin
         case (reg_addr)
            OFS_DL_CTRL:  nxt_st.dl_ctrl  = reg_wdata;
            OFS_TX_BOM:   nxt_st.tx_bom   = reg_wdata;
            OFS_SIG_CTRL: nxt_st.sig_ctrl = reg_wdata;
            default: ;
         endcase
      end
      nxt_st.rdata = 8'h00;
      if (reg_rd) begin
         if (reg_addr == OFS_DL_CTRL) begin
            nxt_st.rdata = st_ff.dl_ctrl;
         end else if (reg_addr == OFS_TX_BOM) begin
            nxt_st.rdata = st_ff.tx_bom;
         end else if (reg_addr == OFS_SIG_CTRL) begin
            nxt_st.rdata = st_ff.sig_ctrl;
         end else if (reg_addr >= OFS_RXSIG_BASE &&
                      reg_addr <  OFS_RXSIG_BASE + 8'(NUM_CH)) begin
            nxt_st.rdata = {4'h0, fmt_nib(st_ff.stable[reg_addr - OFS_RXSIG_BASE],
                            esf_mode, st_ff.sig_ctrl[2:1])};
         end
      end

      // Overhead data link source
      nxt_st.ovh_valid = ovh_req;
      nxt_st.fdl_take  = 1'b0;
      if (ovh_req) begin
         if (ext_en) begin
            nxt_st.ovh_bit = tx_dl_in;
         end else if (bom_en && esf_mode) begin
            nxt_st.ovh_bit = bom_pat[BOM_LEN_LAST - st_ff.bom_idx];
            nxt_st.bom_idx = st_ff.bom_idx + 4'h1;
         end else if (fdl_hdlc_en && esf_mode) begin
            nxt_st.ovh_bit  = hdlc_fdl_bit;
            nxt_st.fdl_take = 1'b1;
         end else begin
            nxt_st.ovh_bit = 1'b1;
         end
      end
      if (!bom_en) begin
         nxt_st.bom_idx = 4'h0;
      end

      // Channel 24 source and rate
      nxt_st.ch24_valid = ch24_req && c24_hdlc_en;
      nxt_st.ch24_take  = 1'b0;
      if (ch24_req && c24_hdlc_en) begin
         if (!rate64 && ch24_bit_idx == CH_BIT8_IDX) begin
            nxt_st.ch24_bit = 1'b1;
         end else begin
            nxt_st.ch24_bit  = hdlc_ch24_bit;
            nxt_st.ch24_take = 1'b1;
         end
      end

      // Multiframe alignment
      nxt_st.mf_align = ch31b0_valid && st_ff.dl_ctrl[BIT_TX_MULTIFRAME_ALIGN];
      if (ch31b0_valid) begin
         nxt_st.mf_sbit = ch31b0_bit;
      end

      // Robbed-bit frame count
      if (frame_start) begin
         nxt_st.frame_cnt = (st_ff.frame_cnt == RB_FRAME_LAST) ? 3'h0
                                                               : st_ff.frame_cnt + 3'h1;
         nxt_st.rb_frame  = st_ff.sig_ctrl[BIT_ROBBED_BIT_ENABLE] &&
                            (nxt_st.frame_cnt == RB_FRAME_LAST);
      end
      if (!st_ff.sig_ctrl[BIT_ROBBED_BIT_ENABLE]) begin
         nxt_st.rb_frame = 1'b0;
      end
      if (tx_sig_valid) begin
         nxt_st.tx_nib = hi_sel ? backplane_signaling_input[7:4]
                                : backplane_signaling_input[3:0];
      end

      // Millisecond tick and debounce timers
      nxt_st.ms_cnt = ms_tick ? '0 : st_ff.ms_cnt + MS_W'(1);
      for (i = 0; i < NUM_CH; i++) begin
         if (st_ff.cand[i] != st_ff.stable[i]) begin
            if (ms_tick && st_ff.db_cnt[i] != DB_TICKS) begin
               nxt_st.db_cnt[i] = st_ff.db_cnt[i] + 3'h1;
            end
            if (st_ff.db_cnt[i] == DB_TICKS) begin
               nxt_st.stable[i] = st_ff.cand[i];
               nxt_st.db_cnt[i] = 3'h0;
            end
         end
      end
      if (rx_sig_valid && ch < 5'(NUM_CH)) begin
         if (!db_en) begin
            nxt_st.stable[ch] = rx_sig_abcd;
            nxt_st.cand[ch]   = rx_sig_abcd;
            nxt_st.db_cnt[ch] = 3'h0;
         end else if (rx_sig_abcd != st_ff.cand[ch]) begin
            nxt_st.cand[ch]   = rx_sig_abcd;
            nxt_st.db_cnt[ch] = 3'h0;
         end
         rep = fmt_nib(nxt_st.stable[ch], esf_mode, st_ff.sig_ctrl[2:1]);
         nxt_st.cst_out = hi_sel ? {rep, 4'h0} : {4'h0, rep};
      end

      nxt_st.dout = line_data;
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_ff          <= '0;
         st_ff.dl_ctrl  <= RST_DL_CTRL;
         st_ff.tx_bom   <= RST_TX_BOM;
         st_ff.sig_ctrl <= RST_SIG_CTRL;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rdata         = st_ff.rdata;
   assign ovh_valid         = st_ff.ovh_valid;
   assign ovh_bit           = st_ff.ovh_bit;
   assign hdlc_fdl_take     = st_ff.fdl_take;
   assign ch24_valid        = st_ff.ch24_valid;
   assign ch24_bit          = st_ff.ch24_bit;
   assign hdlc_ch24_take    = st_ff.ch24_take;
   assign ch24_use_hdlc     = c24_hdlc_en;
   assign tx_mf_align       = st_ff.mf_align;
   assign tx_mf_sbit        = st_ff.mf_sbit;
   assign tx_unframed       = st_ff.dl_ctrl[BIT_TRANSPARENT_SELECT];
   assign rx_unframed       = st_ff.dl_ctrl[BIT_TRANSPARENT_SELECT];
   assign crc_sbit_include  = st_ff.dl_ctrl[BIT_JAPAN_CRC_SBIT_INCLUDE];
   assign rx_bom_capture_en = 1'b1;
   assign hdlc_rx_enable    = 1'b1;
   assign rb_insert_frame   = st_ff.rb_frame;
   assign tx_sig_nibble     = st_ff.tx_nib;

   assign backplane_signaling_output = st_ff.cst_out;
   assign backplane_signaling_output_oe =
      st_ff.sig_ctrl[BIT_SIGNALING_OUT_DRIVE_ENABLE] ?
      (hi_sel ? 8'hF0 : 8'h0F) : 8'h00;

   assign backplane_data_output    = st_ff.dout;
   assign backplane_data_output_oe = st_ff.sig_ctrl[BIT_SERIAL_OUT_DRIVE_ENABLE];

endmodule // tdl_ctrl

`default_nettype wire

// file: testbench/tdl_bp_model.sv
/* Backplane model: signaling bytes and serial data to the block; uses bench clk_sys and nrst. */
`timescale 1ns/100ps
`default_nettype none
module tdl_bp_model (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   // Streams toward the block
   output logic            tx_sig_valid,
   output logic [7:0]      backplane_signaling_input,
   output logic            line_data
);
   logic [7:0] byte_q;
   logic [1:0] ph;
   // ------------------------------------------------------------
   // Byte every fourth cycle, inverted filler between
   // ------------------------------------------------------------
   initial begin
      tx_sig_valid = 1'b0;
      backplane_signaling_input = 8'h00;
      line_data = 1'b0;
      byte_q = 8'h5A;
      ph = 2'h0;
   end
   always @(posedge clk_sys) begin
      ph <= ph + 2'h1;
      line_data <= ~line_data ^ byte_q[0];
      if (nrst && ph == 2'h3) begin
         byte_q <= {byte_q[6:0], byte_q[7] ^ byte_q[5]} ^ 8'h1D;
         tx_sig_valid <= 1'b1;
         backplane_signaling_input <= byte_q;
      end else begin
         tx_sig_valid <= 1'b0;
         backplane_signaling_input <= ~backplane_signaling_input;
      end
   end
endmodule // tdl_bp_model
`default_nettype wire

// file: testbench/tdl_ctrl_props.sv
/* Port-level checker for tdl_ctrl; assumes the bind below, one clk_sys domain, nrst low. */
`timescale 1ns/100ps
`default_nettype none
module tdl_ctrl_props (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       nrst,
   // Data link and channel 24 slots
   input wire logic       ovh_req,
   input wire logic       ovh_valid,
   input wire logic       hdlc_fdl_take,
   input wire logic       ch24_req,
   input wire logic       ch24_use_hdlc,
   input wire logic       ch24_valid,
   input wire logic       hdlc_ch24_take,
   // Alignment and framer controls
   input wire logic       ch31b0_valid,
   input wire logic       ch31b0_bit,
   input wire logic       tx_mf_align,
   input wire logic       tx_mf_sbit,
   input wire logic       rx_bom_capture_en,
   input wire logic       hdlc_rx_enable,
   // Signaling
   input wire logic [7:0] backplane_signaling_output_oe,
   input wire logic       rb_insert_frame,
   input wire logic       frame_start
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_ovh_answer: assert property (ovh_req |=> ovh_valid)
      else $error("data link slot not answered");
   a_ovh_quiet: assert property (!ovh_req |=> !ovh_valid)
      else $error("data link answer without request");
   a_fdl_take: assert property (hdlc_fdl_take |-> ovh_valid)
      else $error("fdl take outside answer");
   a_ch24_answer: assert property (ch24_req && ch24_use_hdlc |=> ch24_valid)
      else $error("channel 24 slot not answered");
   a_ch24_take: assert property (hdlc_ch24_take |-> ch24_valid && $past(ch24_req))
      else $error("channel 24 take outside answer");
   a_align_pulse: assert property (tx_mf_align |-> $past(ch31b0_valid)
      && tx_mf_sbit == $past(ch31b0_bit))
      else $error("alignment pulse without s bit");
   a_rx_always: assert property (rx_bom_capture_en && hdlc_rx_enable)
      else $error("receivers disabled");
   a_sig_oe: assert property (
      backplane_signaling_output_oe inside {8'h00, 8'h0F, 8'hF0})
      else $error("signaling enable pattern bad");
   a_rb_rise: assert property ($rose(rb_insert_frame) |-> $past(frame_start))
      else $error("robbed bit frame off boundary");
endmodule // tdl_ctrl_props

bind tdl_ctrl tdl_ctrl_props u_props (.clk_sys, .nrst, .ovh_req, .ovh_valid, .hdlc_fdl_take,
   .ch24_req, .ch24_use_hdlc, .ch24_valid, .hdlc_ch24_take, .ch31b0_valid, .ch31b0_bit,
   .tx_mf_align, .tx_mf_sbit, .rx_bom_capture_en, .hdlc_rx_enable,
   .backplane_signaling_output_oe, .rb_insert_frame, .frame_start);
`default_nettype wire

// file: testbench/testbench.sv
/* Self-checking bench for tdl_ctrl; assumes tdl_pkg, the backplane model, the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import tdl_pkg::*;
   localparam int MSC = 10;
   logic        clk_sys, nrst, reg_wr, reg_rd, esf_mode, ovh_req, tx_dl_in, hdlc_fdl_bit;
   logic        hdlc_fdl_take, ovh_valid, ovh_bit, ch24_req, hdlc_ch24_bit, hdlc_ch24_take;
   logic        ch24_valid, ch24_bit, ch24_use_hdlc, ch31b0_valid, ch31b0_bit, tx_mf_align;
   logic        tx_mf_sbit, tx_unframed, rx_unframed, crc_sbit_include, rx_bom_capture_en;
   logic        hdlc_rx_enable, frame_start, tx_sig_valid, rb_insert_frame, rx_sig_valid;
   logic        line_data, backplane_data_output, backplane_data_output_oe, pend, sm, dq;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, backplane_signaling_input, dl, sc, bm, rv, sb;
   logic [7:0]  backplane_signaling_output, backplane_signaling_output_oe;
   logic [7:0]  md[6] = '{8'hE0, 8'h80, 8'h60, 8'h40, 8'h20, 8'h00};
   logic [7:0]  sv[5] = '{8'h00, 8'h40, 8'hC8, 8'h48, 8'h80};
   logic [4:0]  rx_sig_ch;
   logic [3:0]  rx_sig_abcd, tx_sig_nibble, st[24];
   logic [2:0]  ch24_bit_idx;
   logic [15:0] lf;
   int          n_mismatch, checks, idx;
   int          cyc = 0;
   tdl_ctrl #(.MS_CYCLES(MSC)) u_dut (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .esf_mode, .ovh_req, .tx_dl_in, .hdlc_fdl_bit, .hdlc_fdl_take,
      .ovh_valid, .ovh_bit, .ch24_req, .ch24_bit_idx, .hdlc_ch24_bit, .hdlc_ch24_take,
      .ch24_valid, .ch24_bit, .ch24_use_hdlc, .ch31b0_valid, .ch31b0_bit, .tx_mf_align,
      .tx_mf_sbit, .tx_unframed, .rx_unframed, .crc_sbit_include, .rx_bom_capture_en,
      .hdlc_rx_enable, .frame_start, .tx_sig_valid, .backplane_signaling_input,
      .rb_insert_frame, .tx_sig_nibble, .rx_sig_valid, .rx_sig_ch, .rx_sig_abcd,
      .backplane_signaling_output, .backplane_signaling_output_oe, .line_data,
      .backplane_data_output, .backplane_data_output_oe);
   tdl_bp_model u_bp (.clk_sys, .nrst, .tx_sig_valid, .backplane_signaling_input, .line_data);
   // ------------------------------------------------------------
   // Clock, timeout, helpers and bus tasks
   // ------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      pend <= tx_sig_valid && nrst;
      sb <= backplane_signaling_input;
      sm <= sc[3];
      dq <= line_data;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   always @(negedge clk_sys) begin
      if (pend) chk({4'h0, tx_sig_nibble}, {4'h0, sm ? sb[7:4] : sb[3:0]});
      if (pend) chk({7'h00, backplane_data_output}, {7'h00, dq});
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic void rnd(output logic [7:0] r);
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      r = lf[7:0];
   endfunction
   function automatic logic [3:0] nib(input logic [3:0] a);
      return esf_mode ? a : {a[3:2], sc[2:1]};
   endfunction
   function automatic logic [7:0] oex();
      return sc[6] ? (sc[3] ? 8'hF0 : 8'h0F) : 8'h00;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
      if (a == OFS_DL_CTRL) dl = d;
      if (a == OFS_SIG_CTRL) sc = d;
      if (a == OFS_TX_BOM) bm = d;
      if (!dl[6]) idx = 0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, x);
   endtask
   // ------------------------------------------------------------
   // Slot tasks with model expectations
   // ------------------------------------------------------------
   task automatic ovh();
      logic [7:0] r;
      logic x, t;
      rnd(r);
      t = dl[5] && esf_mode && !dl[7] && !dl[6];
      if (dl[7]) x = r[0];
      else if (dl[6] && esf_mode) begin
         x = (idx < 8) ? 1'b1 : bm[15-idx];
         idx = (idx + 1) % 16;
      end else x = t ? r[1] : 1'b1;
      @(posedge clk_sys);
      ovh_req <= 1'b1;
      tx_dl_in <= r[0];
      hdlc_fdl_bit <= r[1];
      @(posedge clk_sys);
      ovh_req <= 1'b0;
      #1 chk({5'h00, ovh_valid, hdlc_fdl_take, ovh_bit}, {5'h00, 1'b1, t, x});
   endtask
   task automatic c24(input logic [2:0] i);
      logic [7:0] r;
      logic t;
      rnd(r);
      t = !(i == 3'h7 && !dl[0]);
      @(posedge clk_sys);
      ch24_req <= 1'b1;
      ch24_bit_idx <= i;
      hdlc_ch24_bit <= r[0];
      @(posedge clk_sys);
      ch24_req <= 1'b0;
      #1 chk({5'h00, ch24_valid, hdlc_ch24_take, ch24_bit}, {5'h00, 1'b1, t, t ? r[0] : 1'b1});
   endtask
   task automatic aln();
      rnd(rv);
      @(posedge clk_sys);
      ch31b0_valid <= 1'b1;
      ch31b0_bit <= rv[0];
      @(posedge clk_sys);
      ch31b0_valid <= 1'b0;
      #1 chk({6'h00, tx_mf_align, tx_mf_sbit}, {6'h00, dl[3], rv[0]});
   endtask
   task automatic frm(input int n);
      @(posedge clk_sys);
      frame_start <= 1'b1;
      @(posedge clk_sys);
      frame_start <= 1'b0;
      #1 chk({7'h00, rb_insert_frame}, {7'h00, sc[5] && n % 6 == 5});
   endtask
   task automatic rxs(input logic [4:0] c, input logic [3:0] a, input bit db);
      @(posedge clk_sys);
      rx_sig_valid <= 1'b1;
      rx_sig_ch <= c;
      rx_sig_abcd <= a;
      @(posedge clk_sys);
      rx_sig_valid <= 1'b0;
      if (!db) st[c] = a;
      #1 chk(backplane_signaling_output & oex(), (sc[3] ? {nib(st[c]), 4'h0} :
         {4'h0, nib(st[c])}) & oex());
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {nrst, reg_wr, reg_rd, esf_mode, ovh_req, tx_dl_in, hdlc_fdl_bit, ch24_req, hdlc_ch24_bit,
         ch31b0_valid, ch31b0_bit, frame_start, rx_sig_valid, reg_addr, reg_wdata,
         ch24_bit_idx, rx_sig_ch, rx_sig_abcd} = '0;
      {dl, sc, bm, idx, n_mismatch, checks} = '0;
      lf = 16'hD352;
      st = '{default: 4'h0};
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      rdc(OFS_DL_CTRL, RST_DL_CTRL);
      rdc(OFS_TX_BOM, RST_TX_BOM);
      rdc(OFS_SIG_CTRL, RST_SIG_CTRL);
      rdc(8'h20, 8'h00);
      wr(OFS_SIG_CTRL, 8'h20);
      for (int n = 1; n < 14; n++) frm(n);
      $display("done: reset and robbed bit");
      rnd(rv);
      wr(OFS_TX_BOM, rv & 8'h7E);
      rdc(OFS_TX_BOM, rv & 8'h7E);
      for (int e = 0; e < 2; e++) begin
         esf_mode <= e[0];
         foreach (md[m]) begin
            wr(OFS_DL_CTRL, md[m]);
            rdc(OFS_DL_CTRL, md[m]);
            repeat (32) ovh();
         end
      end
      for (int r = 0; r < 2; r++) begin
         wr(OFS_DL_CTRL, 8'h10 | r[7:0]);
         for (int i = 0; i < 16; i++) c24(i[2:0]);
      end
      $display("done: data link and channel 24");
      foreach (md[m]) begin
         wr(OFS_DL_CTRL, md[m] >> 4 | 8'h08 & md[m]);
         chk({5'h00, tx_unframed, rx_unframed, crc_sbit_include}, {5'h00, {2{dl[2]}}, dl[1]});
         aln();
      end
      foreach (sv[i]) begin
         wr(OFS_SIG_CTRL, sv[i]);
         chk(backplane_signaling_output_oe, oex());
         chk({7'h00, backplane_data_output_oe}, {7'h00, sc[7]});
         repeat (8) @(posedge clk_sys);
      end
      $display("done: modes and output enables");
      for (int e = 0; e < 2; e++) begin
         esf_mode <= e[0];
         wr(OFS_SIG_CTRL, e ? 8'hCE : 8'h44);
         for (int c = 0; c < 24; c++) begin
            rnd(rv);
            rxs(c[4:0], rv[3:0], 1'b0);
            rdc(OFS_RXSIG_BASE + c[7:0], {4'h0, nib(st[c])});
         end
      end
      wr(OFS_RXSIG_BASE + 8'h05, 8'hFF);
      rdc(OFS_RXSIG_BASE + 8'h05, {4'h0, nib(st[5])});
      wr(OFS_SIG_CTRL, 8'h50);
      rv = {4'h0, st[5] ^ 4'h9};
      rxs(5'h05, rv[3:0], 1'b1);
      repeat (40) @(posedge clk_sys);
      rxs(5'h05, rv[3:0], 1'b1);
      repeat (60) @(posedge clk_sys);
      rxs(5'h05, rv[3:0], 1'b0);
      rdc(OFS_RXSIG_BASE + 8'h05, {4'h0, nib(st[5])});
      $display("done: receive signaling");
      conclude();
   end
endmodule // testbench
`default_nettype wire
